//--- design/itc_pkg.sv
// Shared constants for the isochronous transmit context control block
package itc_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int ADDR_W  = 12;  // Byte address width
    localparam int DATA_W  = 32;  // Register data width
    localparam int NUM_CTX = 8;   // Transmit contexts
    localparam int CODE_W  = 5;   // Completion code width
    localparam int EVT_W   = 16;  // Interrupt event bits

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [11:0] CTX_SET_BASE   = 12'h200;  // Set address, ctx 0
    localparam logic [11:0] CTX_CLR_BASE   = 12'h204;  // Clear address, ctx 0
    localparam logic [11:0] CTX_STRIDE     = 12'h010;  // Step per context
    localparam logic [11:0] IRQ_STATUS_OFF = 12'h100;  // Sticky event status
    localparam logic [11:0] IRQ_MASK_OFF   = 12'h104;  // Event mask

    // ==========================================================
    // Field positions of the context control word and event status
    // ==========================================================
    localparam int RUN_BIT    = 15;  // Run
    localparam int WAKE_BIT   = 12;  // Resume request
    localparam int DEAD_BIT   = 11;  // Fatal halt
    localparam int ACTIVE_BIT = 10;  // Processing
    localparam int CODE_LSB   = 0;   // Completion code, 5 bits
    localparam int FATAL_EVT  = 0;   // Fatal events in status 7..0
    localparam int DONE_EVT   = 8;   // Completion events in 15..8

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic              RUN_RST    = 1'b0;
    localparam logic              WAKE_RST   = 1'b0;
    localparam logic              DEAD_RST   = 1'b0;
    localparam logic              ACTIVE_RST = 1'b0;
    localparam logic [4:0]        CODE_RST   = 5'h00;
    localparam logic [15:0]       EVT_RST    = 16'h0000;
    localparam logic [31:0]       RD_RST     = 32'h00000000;

endpackage : itc_pkg

//--- design/itc_irq.sv
// Sticky event status, mask and level interrupt for the context block
`timescale 1ns/10ps

module itc_irq
    import itc_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Events and software access
    input  wire logic [EVT_W-1:0] evtPulse,
    input  wire logic             statusWrite,
    input  wire logic             maskWrite,
    input  wire logic [EVT_W-1:0] wrData,
    // State and interrupt
    output logic      [EVT_W-1:0] status_reg,
    output logic      [EVT_W-1:0] mask_reg,
    output logic                  irq_reg
);

    logic [EVT_W-1:0] status_next;  // Status after this cycle
    logic [EVT_W-1:0] mask_next;    // Mask after this cycle

    // ==========================================================
    // Next values
    // ==========================================================
    // Write one clears; a new event in the same cycle wins
    always_comb
    begin
        status_next = status_reg;
        if (statusWrite)
        begin
            status_next = status_reg & ~wrData;
        end
        status_next = status_next | evtPulse;
        mask_next   = maskWrite ? wrData : mask_reg;
    end

    // Status, mask and interrupt flops
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            status_reg <= EVT_RST;
            mask_reg   <= EVT_RST;
            irq_reg    <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            irq_reg    <= |(status_next & mask_next);
        end
    end

endmodule : itc_irq

//--- design/itc_context_ctrl.sv
// Control and status of eight isochronous transmit DMA contexts
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps

module itc_context_ctrl
    import itc_pkg::*;
(
    // Clock and resets
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               softReset,
    // Register port
    input  wire logic [ADDR_W-1:0]  regAddr,
    input  wire logic [DATA_W-1:0]  regWrData,
    input  wire logic               regWrite,
    input  wire logic               regRead,
    output logic      [DATA_W-1:0]  regRdData,
    // Descriptor engine status, one bit per context, plus a shared completion code
    input  wire logic [NUM_CTX-1:0] fetchStrobe,
    input  wire logic [NUM_CTX-1:0] fatalError,
    input  wire logic [NUM_CTX-1:0] ctxIdle,
    input  wire logic [NUM_CTX-1:0] doneValid,
    input  wire logic [CODE_W-1:0]  doneCode,
    // Descriptor engine control, one bit per context
    output logic      [NUM_CTX-1:0] runEnable,
    output logic      [NUM_CTX-1:0] startReq,
    output logic      [NUM_CTX-1:0] wakeReq,
    // Interrupt
    output logic                    irq
);

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [NUM_CTX-1:0] run_reg;       // Run bits
    logic [NUM_CTX-1:0] wake_reg;      // Resume request bits
    logic [NUM_CTX-1:0] dead_reg;      // Fatal halt bits
    logic [NUM_CTX-1:0] active_reg;    // Processing bits
    logic [NUM_CTX-1:0] start_reg;     // Start pulses
    logic [NUM_CTX-1:0] wakeOut_reg;   // Resume pulses
    logic [CODE_W-1:0]  code_reg [NUM_CTX];  // Completion codes
    logic [DATA_W-1:0]  ctrlWord [NUM_CTX];  // Readable control words
    logic [NUM_CTX-1:0] setHit;        // Write to a set address
    logic [NUM_CTX-1:0] clrHit;        // Write to a clear address
    logic [NUM_CTX-1:0] runRise;       // Run going 0 to 1
    logic [NUM_CTX-1:0] runFall;       // Run going 1 to 0
    logic [NUM_CTX-1:0] wakeSet;       // Software writes wake
    logic [DATA_W-1:0]  rd_reg;        // Read data flop
    logic [DATA_W-1:0]  rd_next;       // Read data next value
    logic               rdCtx_next;    // Read address hits a context
    logic               rdCtx_reg;     // Read data hold a context word
    logic [EVT_W-1:0]   evtPulse;      // Events to the status register
    logic [EVT_W-1:0]   irqStatus;     // Sticky status
    logic [EVT_W-1:0]   irqMask;       // Event mask
    logic               irq_reg;       // Interrupt flop
    logic               statusWrite;   // Write to status
    logic               maskWrite;     // Write to mask

    // ==========================================================
    // Per-context logic
    // ==========================================================
    // one copy per context
    for (genvar g = 0; g < NUM_CTX; g++)
    begin : gCtx
        localparam logic [11:0] OFF = CTX_STRIDE * 12'(g);

        assign setHit[g]  = regWrite && (regAddr == CTX_SET_BASE + OFF);
        assign clrHit[g]  = regWrite && (regAddr == CTX_CLR_BASE + OFF);
        assign runRise[g] = setHit[g] && regWrData[RUN_BIT] && !run_reg[g];
        assign runFall[g] = clrHit[g] && regWrData[RUN_BIT] && run_reg[g];
        assign wakeSet[g] = setHit[g] && regWrData[WAKE_BIT];

        // run moves only by software or reset
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                run_reg[g] <= RUN_RST;
            end
            else if (softReset)
            begin
                run_reg[g] <= RUN_RST;
            end
            else if (runRise[g])
            begin
                run_reg[g] <= 1'b1;
            end
            else if (runFall[g])
            begin
                run_reg[g] <= 1'b0;
            end
        end

        // Resume request: software sets, a fetch clears, set wins
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                wake_reg[g] <= WAKE_RST;
            end
            else if (softReset)
            begin
                wake_reg[g] <= WAKE_RST;
            end
            else if (wakeSet[g])
            begin
                wake_reg[g] <= 1'b1;
            end
            else if (fetchStrobe[g])
            begin
                wake_reg[g] <= 1'b0;
            end
        end

        // Fatal halt: error while running sets, run clear resets, set wins
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                dead_reg[g] <= DEAD_RST;
            end
            else if (fatalError[g] && run_reg[g])
            begin
                dead_reg[g] <= 1'b1;
            end
            else if (runFall[g] || softReset)
            begin
                dead_reg[g] <= 1'b0;
            end
        end

        // Processing flag
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                active_reg[g] <= ACTIVE_RST;
            end
            // stop, fatal or idle ends processing
            else if (softReset || fatalError[g] || runFall[g]
                     || ctxIdle[g] || dead_reg[g])
            begin
                active_reg[g] <= 1'b0;
            end
            // start or resume makes it active
            else if (runRise[g] || (wakeSet[g] && run_reg[g]))
            begin
                active_reg[g] <= 1'b1;
            end
        end

        // Start and resume pulses toward the descriptor engine
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                start_reg[g]   <= 1'b0;
                wakeOut_reg[g] <= 1'b0;
            end
            else
            begin
                start_reg[g]   <= runRise[g] && !softReset;
                wakeOut_reg[g] <= wakeSet[g] && run_reg[g]
                                  && !dead_reg[g] && !softReset;
            end
        end

        // Completion code after a final output descriptor
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                code_reg[g] <= CODE_RST;
            end
            else if (doneValid[g])
            begin
                code_reg[g] <= doneCode;
            end
        end

        // Readable word; reserved zero, speed zero
        always_comb
        begin
            ctrlWord[g]                 = RD_RST;
            ctrlWord[g][RUN_BIT]        = run_reg[g];
            ctrlWord[g][WAKE_BIT]       = wake_reg[g];
            ctrlWord[g][DEAD_BIT]       = dead_reg[g];
            ctrlWord[g][ACTIVE_BIT]     = active_reg[g];
            ctrlWord[g][CODE_LSB +: CODE_W] = code_reg[g];
        end

        // Run only changes under a software write or reset
        // no self change
        run_stable_a: assert property (@(posedge clock)
            disable iff (rst)
            !$past(setHit[g]) && !$past(clrHit[g]) && !$past(softReset)
            |-> $stable(run_reg[g]))
            else $error("run changed without software");
        run_clear_a: assert property (@(posedge clock)
            disable iff (rst)
            clrHit[g] && regWrData[RUN_BIT] |=> !run_reg[g])
            else $error("run not cleared by clear write");
        wake_fetch_a: assert property (@(posedge clock)
            disable iff (rst)
            fetchStrobe[g] && !wakeSet[g] |=> !wake_reg[g])
            else $error("wake survived a fetch");
        dead_set_a: assert property (@(posedge clock)
            disable iff (rst)
            fatalError[g] && run_reg[g] |=> dead_reg[g] && !active_reg[g])
            else $error("fatal error not reported");
        dead_clear_a: assert property (@(posedge clock)
            disable iff (rst)
            runFall[g] && !fatalError[g] |=> !dead_reg[g] && !active_reg[g])
            else $error("halt not cleared on stop");
        start_pulse_a: assert property (@(posedge clock)
            disable iff (rst)
            runRise[g] && !softReset |=> startReq[g] && run_reg[g]
            ##1 !startReq[g])
            else $error("start pulse missing");
        active_run_a: assert property (@(posedge clock)
            disable iff (rst)
            active_reg[g] |-> run_reg[g] && !dead_reg[g])
            else $error("active without run");
        code_store_a: assert property (@(posedge clock)
            disable iff (rst)
            doneValid[g] |=> code_reg[g] == $past(doneCode))
            else $error("completion code not stored");
    end

    // ==========================================================
    // Interrupt events and register
    // ==========================================================
    // Fatal and completion events per context
    assign evtPulse[FATAL_EVT +: NUM_CTX] = fatalError & run_reg;
    assign evtPulse[DONE_EVT +: NUM_CTX]  = doneValid;
    assign statusWrite = regWrite && (regAddr == IRQ_STATUS_OFF);
    assign maskWrite   = regWrite && (regAddr == IRQ_MASK_OFF);

    // Sticky status, mask and interrupt level
    itc_irq uIrq
    (
        .clock       (clock),
        .rst         (rst),
        .evtPulse    (evtPulse),
        .statusWrite (statusWrite),
        .maskWrite   (maskWrite),
        .wrData      (regWrData[EVT_W-1:0]),
        .status_reg  (irqStatus),
        .mask_reg    (irqMask),
        .irq_reg     (irq_reg)
    );

    // ==========================================================
    // Read path
    // ==========================================================
    // Decode the read address; unmapped reads return zero
    always_comb
    begin
        rd_next    = RD_RST;
        rdCtx_next = 1'b0;
        if (regAddr == IRQ_STATUS_OFF)
        begin
            rd_next[EVT_W-1:0] = irqStatus;
        end
        else if (regAddr == IRQ_MASK_OFF)
        begin
            rd_next[EVT_W-1:0] = irqMask;
        end
        for (int k = 0; k < NUM_CTX; k++)
        begin
            if (regAddr == CTX_SET_BASE + CTX_STRIDE * 12'(k)
                || regAddr == CTX_CLR_BASE + CTX_STRIDE * 12'(k))
            begin
                rd_next    = ctrlWord[k];
                rdCtx_next = 1'b1;
            end
        end
    end

    // Read data stand for one cycle after the strobe only
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rd_reg    <= RD_RST;
            rdCtx_reg <= 1'b0;
        end
        else
        begin
            rd_reg    <= regRead ? rd_next : RD_RST;
            // Marks context words; status and mask use these bit places
            rdCtx_reg <= regRead && rdCtx_next;
        end
    end

    rsvd_high_a: assert property (@(posedge clock)
        disable iff (rst)
        rdCtx_reg |-> rd_reg[14:13] == 2'b00)
        else $error("reserved bits 14 13 not zero");
    // reserved 9 8 zero, speed zero
    rsvd_low_a: assert property (@(posedge clock)
        disable iff (rst)
        rdCtx_reg |-> rd_reg[9:8] == 2'b00 && rd_reg[7:5] == 3'b000)
        else $error("reserved bits 9 8 or speed not zero");

    // Main scenarios
    run_start_c: cover property (@(posedge clock) disable iff (rst)
        runRise[0] ##1 startReq[0]);
    fatal_stop_c: cover property (@(posedge clock) disable iff (rst)
        dead_reg[0] ##[1:20] runFall[0]);
    wake_fetch_c: cover property (@(posedge clock) disable iff (rst)
        wakeReq[1] ##[1:20] fetchStrobe[1]);
    irq_raise_c: cover property (@(posedge clock) disable iff (rst)
        doneValid[2] ##[1:3] irq);

    // ==========================================================
    // Outputs
    // ==========================================================
    assign regRdData = rd_reg;
    assign runEnable = run_reg;
    assign startReq  = start_reg;
    assign wakeReq   = wakeOut_reg;
    assign irq       = irq_reg;

endmodule : itc_context_ctrl

//--- bench/itc_engine_model.sv
// Descriptor engine stand-in that answers start and wake requests
`timescale 1ns/10ps

module itc_engine_model
    import itc_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // Requests from the block and pacing
    input  wire logic [NUM_CTX-1:0] startReq,
    input  wire logic [NUM_CTX-1:0] wakeReq,
    input  wire logic               slow,
    // Fetch pulses back to the block
    output logic      [NUM_CTX-1:0] fetchStrobe
);
    // ==========================================================
    // Fetch pacing
    // ==========================================================
    logic [2:0] waitCnt [NUM_CTX];  // Cycles left before a fetch

    // fetch after start
    // Each request restarts a short or long wait, then one fetch
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            fetchStrobe <= '0;
            for (int i = 0; i < NUM_CTX; i++)
                waitCnt[i] <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < NUM_CTX; i++)
            begin
                // Prompt answer takes one cycle, slow takes four
                if (startReq[i] || wakeReq[i])
                    waitCnt[i] <= slow ? 3'h4 : 3'h1;
                else if (waitCnt[i] != 3'h0)
                    waitCnt[i] <= waitCnt[i] - 3'h1;
                fetchStrobe[i] <= (waitCnt[i] == 3'h1);
            end
        end
    end
endmodule : itc_engine_model

//--- bench/tb.sv
// Self-checking bench for the transmit context control block
`timescale 1ns/10ps

module tb;
    import itc_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic               clock, rst, softReset;
    logic [ADDR_W-1:0]  regAddr;
    logic [DATA_W-1:0]  regWrData, regRdData, head;
    logic               regWrite, regRead, irq, slow, rdPend;
    logic [NUM_CTX-1:0] fetchStrobe, fatalError, ctxIdle, doneValid;
    logic [NUM_CTX-1:0] runEnable, startReq, wakeReq;
    logic [CODE_W-1:0]  doneCode, code;
    logic [31:0]        expQ [$];    // Expected read words
    logic [31:0]        stat;        // Expected event status
    int                 errTotal, testsRun, c, o, n, k;
    // Control word bit values
    localparam logic [31:0] RUNV = 32'h00008000;
    localparam logic [31:0] WAKV = 32'h00001000;
    localparam logic [31:0] DEDV = 32'h00000800;
    localparam logic [31:0] ACTV = 32'h00000400;

    // ==========================================================
    // Design, engine model and clock
    // ==========================================================
    itc_context_ctrl uut (.clock(clock), .rst(rst), .softReset(softReset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData),
        .fetchStrobe(fetchStrobe), .fatalError(fatalError),
        .ctxIdle(ctxIdle), .doneValid(doneValid), .doneCode(doneCode),
        .runEnable(runEnable), .startReq(startReq), .wakeReq(wakeReq),
        .irq(irq));
    itc_engine_model engine (.clock(clock), .rst(rst),
        .startReq(startReq), .wakeReq(wakeReq), .slow(slow),
        .fetchStrobe(fetchStrobe));

    // 20 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [11:0] setA(input int i);
        return CTX_SET_BASE + CTX_STRIDE * 12'(i);
    endfunction : setA
    function automatic logic [11:0] clrA(input int i);
        return CTX_CLR_BASE + CTX_STRIDE * 12'(i);
    endfunction : clrA

    // Prints counts and verdict, then stops
    task automatic completeRun();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : completeRun

    // Compares a port value against its expectation
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        testsRun++;
        if (got !== exp)
        begin
            errTotal++;
            $display("unexpected at %0t: %s got %h", $time, msg, got);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clock);
        regWrite  <= 1'b0;
    endtask : wr

    // One-cycle register read, expectation queued for the monitor
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(e);
        @(posedge clock);
        regRead <= 1'b0;
    endtask : rd

    // One-cycle engine event: 0 fatal, 1 idle, 2 done, 3 soft reset
    task automatic pulse(input int kind, input int i,
                         input logic [4:0] cd);
        @(posedge clock);
        doneCode <= cd;
        case (kind)
            0:       fatalError <= 8'h01 << i;
            1:       ctxIdle    <= 8'h01 << i;
            2:       doneValid  <= 8'h01 << i;
            default: softReset  <= 1'b1;
        endcase
        @(posedge clock);
        fatalError <= '0;
        ctxIdle    <= '0;
        doneValid  <= '0;
        softReset  <= 1'b0;
    endtask : pulse

    // Bounded wait for the engine's fetch of one context
    task automatic waitFetch(input int i);
        int t;
        for (t = 0; t < 12; t++)
        begin
            @(posedge clock);
            if (fetchStrobe[i] === 1'b1)
                break;
        end
        if (t == 12)
        begin
            errTotal++;
            $display("unexpected at %0t: no fetch", $time);
            completeRun();
        end
    endtask : waitFetch

    // Settles an interrupt change before it is looked at
    task automatic irqChk(input logic e);
        repeat (2) @(posedge clock);
        #1;
        chk({31'h0, irq}, {31'h0, e}, "irq level");
    endtask : irqChk

    // ==========================================================
    // Read monitor: oldest note against the returned word
    // ==========================================================
    always @(posedge clock)
    begin
        if (rdPend)
        begin
            testsRun++;
            head = (expQ.size() > 0) ? expQ.pop_front() : 32'hDEADBEEF;
            if (regRdData !== head)
            begin
                errTotal++;
                $display("unexpected at %0t: read %h want %h", $time,
                         regRdData, head);
            end
        end
        rdPend <= regRead;
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        {rst, softReset, regWrite, regRead, slow} = 5'b10000;
        {regAddr, regWrData, fatalError, ctxIdle, doneValid} = '0;
        {doneCode, errTotal, testsRun, stat} = '0;
        void'($urandom(32'h85677A51));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        c = $urandom % 8;
        o = (c + 1) % 8;
        // Reset words of every context, unmapped place, status
        for (n = 0; n < 8; n++)
        begin
            rd(setA(n), 32'h0);
            rd(clrA(n), 32'h0);
        end
        rd(12'h20C, 32'h0);
        rd(IRQ_STATUS_OFF, 32'h0);
        // Start one context
        wr(setA(c), RUNV);
        #1;
        chk(32'(startReq), 32'h1 << c, "start pulse");
        chk(32'(runEnable), 32'h1 << c, "run level");
        waitFetch(c);
        rd(setA(c), RUNV | ACTV);
        rd(clrA(c), RUNV | ACTV);
        rd(setA(o), 32'h0);
        // Wake written with every other bit but run, slow engine
        slow <= 1'b1;
        wr(setA(c), 32'hFFFF7FFF);
        #1;
        chk(32'(wakeReq), 32'h1 << c, "wake pulse");
        rd(setA(c), RUNV | WAKV | ACTV);
        waitFetch(c);
        rd(setA(c), RUNV | ACTV);
        // Engine goes idle, run stays
        pulse(1, c, 5'h00);
        rd(setA(c), RUNV);
        wr(clrA(c), 32'hFFFFFFFF);
        rd(setA(c), 32'h0);
        // Fatal halt while running
        wr(setA(c), RUNV);
        waitFetch(c);
        pulse(0, c, 5'h00);
        rd(setA(c), RUNV | DEDV);
        wr(IRQ_MASK_OFF, 32'h1 << c);
        irqChk(1'b1);
        wr(clrA(c), RUNV);
        rd(setA(c), 32'h0);
        pulse(0, c, 5'h00);
        rd(setA(c), 32'h0);
        rd(IRQ_STATUS_OFF, 32'h1 << c);
        wr(IRQ_STATUS_OFF, 32'h1 << c);
        irqChk(1'b0);
        rd(IRQ_STATUS_OFF, 32'h0);
        // Software reset drops run and wake
        wr(setA(o), RUNV);
        wr(setA(o), WAKV);
        pulse(3, 0, 5'h00);
        rd(setA(o), 32'h0);
        chk(32'(runEnable), 32'h0, "run after soft reset");
        // Four completion events with random codes and contexts
        wr(IRQ_MASK_OFF, 32'h0000FFFF);
        for (k = 0; k < 4; k++)
        begin
            n = $urandom % 8;
            code = 5'($urandom);
            stat = stat | (32'h100 << n);
            pulse(2, n, code);
            rd(setA(n), {27'h0, code});
            rd(IRQ_STATUS_OFF, stat);
        end
        irqChk(1'b1);
        wr(IRQ_STATUS_OFF, 32'h0000FFFF);
        irqChk(1'b0);
        repeat (3) @(posedge clock);
        completeRun();
    end
endmodule : tb
